// ==== sim/cgfc_csrs_tb.sv ====
// self-checking bench for the colour balance and tone curve registers
`timescale 1ns/1ps

module cgfc_csrs_tb;
  logic        sys_clk         = 1'b0;
  logic        resetn          = 1'b0;
  logic [11:0] avs_address     = 12'h000;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h00000000;
  logic [3:0]  avs_byteenable  = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [5:0]  flg             = 6'h00;  // tone curve auto,on,push then colour balance auto,on,push
  logic [11:0] blue_level_q;
  logic [11:0] red_level_q;
  logic [11:0] gamma_level_q;
  logic        wb_push_act_q;
  logic        gm_push_act_q;
  logic [31:0] m_wb            = 32'h00000000;
  logic [31:0] m_gm            = 32'h00000000;
  logic [31:0] r;
  logic [31:0] d;
  logic [31:0] exp_q[$];
  integer      i;
  integer      seed            = 32'h031f1687;
  integer      fail_count      = 0;
  integer      checks          = 0;

  always #2 sys_clk = ~sys_clk;

  cgfc_csrs cgfc_csrs_inst (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .wb_one_push     (flg[0]),
    .wb_on           (flg[1]),
    .wb_auto         (flg[2]),
    .gm_one_push     (flg[3]),
    .gm_on           (flg[4]),
    .gm_auto         (flg[5]),
    .blue_level_q    (blue_level_q),
    .red_level_q     (red_level_q),
    .gamma_level_q   (gamma_level_q),
    .wb_push_act_q   (wb_push_act_q),
    .gm_push_act_q   (gm_push_act_q)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    if (a == 12'h80c) return {m_wb[31:8], flg[2:0], 5'b00001};
    if (a == 12'h818) return {m_gm[31:20], 12'h000, flg[5:3], 5'b00001};
    return 32'h00000000;
  endfunction

  task automatic set_flg(input logic [5:0] v);
    @(posedge sys_clk);
    flg <= v;
  endtask

  // one bus access; the model follows the stored fields, only lanes enabled and only while on
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] bm;
    integer      n;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    if (!wr) exp_q.push_back(exp_rd(a));
    do begin
      @(posedge sys_clk);
      n = n + 1;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk(n, 32'd2);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!wr) chk(avs_readdata, exp_q.pop_front());
    else if (a == 12'h80c && flg[1]) m_wb = (m_wb & ~(32'hffffff00 & bm)) | (wd & 32'hffffff00 & bm);
    else if (a == 12'h818 && flg[4]) m_gm = (m_gm & ~(32'hfff00000 & bm)) | (wd & 32'hfff00000 & bm);
    @(posedge sys_clk);
    #1;
    chk({20'h00000, blue_level_q}, {20'h00000, m_wb[19:8]});
    chk({20'h00000, red_level_q}, {20'h00000, m_wb[31:20]});
    chk({20'h00000, gamma_level_q}, {20'h00000, m_gm[31:20]});
    chk({30'h0, wb_push_act_q, gm_push_act_q}, {30'h0, flg[0] & ~flg[2], flg[3] & ~flg[5]});
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fail_count = fail_count + 1;
    $display("[FAIL] %0t: watchdog expired", $time);
    test_done;
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    access(1'b0, 12'h80c, 32'h00000000, 4'h0);
    access(1'b0, 12'h818, 32'h00000000, 4'h0);
    $display("test reset values done");
    // first pass with both controls off must leave every field locked
    for (i = 0; i < 2; i++) begin
      set_flg(i ? 6'b010010 : 6'b101101);
      access(1'b1, 12'h80c, 32'hffffffff, 4'hf);
      access(1'b1, 12'h818, 32'hffffffff, 4'hf);
      access(1'b0, 12'h80c, 32'h00000000, 4'h0);
      access(1'b0, 12'h818, 32'h00000000, 4'h0);
    end
    $display("test lock and read-only bits done");
    for (i = 0; i < 80; i++) begin
      r = $random(seed);
      d = $random(seed);
      set_flg(r[13:8]);
      access(r[0], r[1] ? (r[2] ? 12'h80c : 12'h818) : r[31:20], d, r[7:4]);
    end
    $display("test random traffic done");
    // a second reset in mid-run must clear every stored field
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    m_wb = 32'h00000000;
    m_gm = 32'h00000000;
    access(1'b0, 12'h80c, 32'h00000000, 4'h0);
    access(1'b0, 12'h818, 32'h00000000, 4'h0);
    $display("test mid-run reset done");
    test_done;
  end
endmodule

// ==== verilog/cgfc_csrs.sv ====
// colour balance and tone curve control registers behind an avalon-mm slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cgfc_defs.svh"

module cgfc_csrs
  import cgfc_pkg::*;
(
  input  wire logic        sys_clk,           // 250 mhz clock
  input  wire logic        resetn,            // synchronous reset, active low
  input  wire logic [11:0] avs_address,       // byte address
  input  wire logic        avs_read,          // read request
  input  wire logic        avs_write,         // write request
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte lanes of the write
  output logic [31:0]      avs_readdata,      // read data, valid with waitrequest low
  output logic             avs_waitrequest,   // low for one cycle per access
  input  wire logic        wb_one_push,       // colour balance one-shot running
  input  wire logic        wb_on,             // colour balance control on
  input  wire logic        wb_auto,           // colour balance automatic mode
  input  wire logic        gm_one_push,       // tone curve one-shot running
  input  wire logic        gm_on,             // tone curve control on
  input  wire logic        gm_auto,           // tone curve automatic mode
  output logic [11:0]      blue_level_q,      // blue level to the pipeline
  output logic [11:0]      red_level_q,       // red level to the pipeline
  output logic [11:0]      gamma_level_q,     // tone curve value to the pipeline
  output logic             wb_push_act_q,     // colour balance one-shot in effect
  output logic             gm_push_act_q      // tone curve one-shot in effect
);

  cgfc_state_t st_q;
  logic [31:0] wb_fld_q;
  logic [31:0] gm_fld_q;
  logic        req;
  logic        wr_ack;
  logic        hit_wb;
  logic        hit_gm;

  // flag byte common to both registers
  function automatic logic [7:0] cgfc_flags(
    input logic op,
    input logic on,
    input logic au
  );
    logic [7:0] f;
    f = 8'h00;
    f[`CGFC_PRESENT_BIT] = `CGFC_PRESENT;
    f[`CGFC_ABS_BIT]     = `CGFC_ABS_CTL;
    f[`CGFC_PUSH_BIT]    = op;
    f[`CGFC_ON_BIT]      = on;
    f[`CGFC_AUTO_BIT]    = au;
    return f;
  endfunction

  // byte-lane write merge limited to the writable field bits
  function automatic logic [31:0] cgfc_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be,
    input logic [31:0] fmask
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & fmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  assign req    = avs_read | avs_write;
  assign wr_ack = (st_q == CGFC_ACK) && avs_write;
  assign hit_wb = (avs_address == `CGFC_WB_OFS);
  assign hit_gm = (avs_address == `CGFC_GM_OFS);

  // two-cycle handshake: sample the request, then drop waitrequest for one cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q            <= CGFC_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (st_q)
        CGFC_IDLE: begin
          if (req) begin
            st_q            <= CGFC_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        CGFC_ACK: begin
          st_q            <= CGFC_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          st_q            <= CGFC_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read data is captured when the request is first seen and held through the ack
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      avs_readdata <= `CGFC_RD_NONE;
    end else if (st_q == CGFC_IDLE && avs_read) begin
      if (hit_wb) begin
        avs_readdata <= {wb_fld_q[31:8], cgfc_flags(wb_one_push, wb_on, wb_auto)};
      end else if (hit_gm) begin
        avs_readdata <= {gm_fld_q[31:8], cgfc_flags(gm_one_push, gm_on, gm_auto)};
      end else begin
        avs_readdata <= `CGFC_RD_NONE;
      end
    end
  end

  // colour balance fields; locked while the control is off
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wb_fld_q <= `CGFC_WB_RST;
    end else if (wr_ack && hit_wb && wb_on) begin
      wb_fld_q <= cgfc_merge(wb_fld_q, avs_writedata, avs_byteenable, `CGFC_WB_WMASK);
    end
  end

  // tone curve field; bits 8 to 19 are never stored
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gm_fld_q <= `CGFC_GM_RST;
    end else if (wr_ack && hit_gm && gm_on) begin
      gm_fld_q <= cgfc_merge(gm_fld_q, avs_writedata, avs_byteenable, `CGFC_GM_WMASK);
    end
  end

  // applied levels; with no absolute register the value fields always drive the pipeline
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      blue_level_q  <= `CGFC_LVL_RST;
      red_level_q   <= `CGFC_LVL_RST;
      gamma_level_q <= `CGFC_LVL_RST;
    end else if (`CGFC_ABS_CTL == 1'b0) begin
      blue_level_q  <= wb_fld_q[19:8];
      red_level_q   <= wb_fld_q[31:20];
      gamma_level_q <= gm_fld_q[31:20];
    end
  end

  // one-shot has no meaning in automatic mode, so it is masked there
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wb_push_act_q <= 1'b0;
      gm_push_act_q <= 1'b0;
    end else begin
      wb_push_act_q <= wb_one_push & ~wb_auto;
      gm_push_act_q <= gm_one_push & ~gm_auto;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!resetn);

  a_ack_one_cycle: assert property (
    (st_q == CGFC_ACK) |-> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");

  a_req_answered: assert property (
    (st_q == CGFC_IDLE && req) |=> (st_q == CGFC_ACK && !avs_waitrequest))
    else $error("request not answered on the next edge");

  a_presence_bit: assert property (
    (st_q == CGFC_ACK && avs_read && (hit_wb || hit_gm)) |-> avs_readdata[0] == 1'b1)
    else $error("presence flag not reported");

  a_value_source: assert property (
    1'b1 |=> (blue_level_q == $past(wb_fld_q[19:8]) && gamma_level_q == $past(gm_fld_q[31:20])))
    else $error("applied level does not follow value field");

  a_abs_readonly: assert property (
    (st_q == CGFC_ACK && avs_read) |-> avs_readdata[1] == 1'b0)
    else $error("source select flag not zero");

  a_push_masked: assert property (
    (wb_auto || gm_auto) |=> !(wb_push_act_q && $past(wb_auto)) && !(gm_push_act_q && $past(gm_auto)))
    else $error("one-shot acted on in automatic mode");

  a_off_locked: assert property (
    (wr_ack && hit_wb && !wb_on) |=> $stable(wb_fld_q))
    else $error("colour balance written while off");

  a_mode_flag: assert property (
    (st_q == CGFC_ACK && avs_read && hit_wb) |-> avs_readdata[7] == $past(wb_auto))
    else $error("mode flag does not follow automatic state");

  a_blue_write: assert property (
    (wr_ack && hit_wb && wb_on && avs_byteenable == 4'hf)
      |=> wb_fld_q[19:8] == $past(avs_writedata[19:8]) ##1 blue_level_q == $past(wb_fld_q[19:8]))
    else $error("blue level not taken from bits 8 to 19");

  a_red_write: assert property (
    (wr_ack && hit_wb && wb_on && avs_byteenable == 4'hf)
      |=> wb_fld_q[31:20] == $past(avs_writedata[31:20]) ##1 red_level_q == $past(wb_fld_q[31:20]))
    else $error("red level not taken from bits 20 to 31");

  a_gamma_write: assert property (
    (wr_ack && hit_gm && gm_on && avs_byteenable == 4'hf)
      |=> gm_fld_q[31:20] == $past(avs_writedata[31:20]) && gm_fld_q[19:0] == 20'h00000)
    else $error("tone curve value misplaced");

  a_reserved_flags: assert property (
    (st_q == CGFC_ACK && avs_read) |-> avs_readdata[4:2] == 3'h0)
    else $error("reserved flag bits not zero");

  a_reserved_zero: assert property (
    (wb_fld_q[7:0] == 8'h00 && gm_fld_q[19:0] == 20'h00000
      && !(st_q == CGFC_ACK && avs_read && !hit_wb && !hit_gm && avs_readdata != 32'h0)))
    else $error("reserved bits hold data");

  // handshake shape and read data holding
  a_idle_waits: assert property (
    (st_q == CGFC_IDLE) |-> avs_waitrequest)
    else $error("waitrequest low outside an acknowledge");

  a_state_onehot: assert property (
    $onehot(st_q))
    else $error("handshake state not one-hot");

  a_ack_returns: assert property (
    (st_q == CGFC_ACK) |=> (st_q == CGFC_IDLE))
    else $error("acknowledge state held for more than one cycle");

  a_rdata_holds: assert property (
    (st_q == CGFC_ACK)
      |=> $stable(avs_readdata))
    else $error("read data changed right after the acknowledge");

  // flag byte and readback of the stored fields
  a_wb_flags_read: assert property (
    (st_q == CGFC_ACK && avs_read && hit_wb)
      |-> avs_readdata[7:5] == {$past(wb_auto), $past(wb_on), $past(wb_one_push)})
    else $error("colour balance flag bits misreported");

  a_gm_flags_read: assert property (
    (st_q == CGFC_ACK && avs_read && hit_gm)
      |-> avs_readdata[7:5] == {$past(gm_auto), $past(gm_on), $past(gm_one_push)})
    else $error("tone curve flag bits misreported");

  a_wb_readback: assert property (
    (st_q == CGFC_ACK && avs_read && hit_wb)
      |-> avs_readdata[31:8] == $past(wb_fld_q[31:8]))
    else $error("colour balance levels misreported");

  a_gm_readback: assert property (
    (st_q == CGFC_ACK && avs_read && hit_gm)
      |-> avs_readdata[31:8] == {$past(gm_fld_q[31:20]), 12'h000})
    else $error("tone curve value misreported");

  a_unmapped_read: assert property (
    (st_q == CGFC_ACK && avs_read && !hit_wb && !hit_gm)
      |-> avs_readdata == `CGFC_RD_NONE)
    else $error("unmapped read returned data");

  // stored fields change only through an accepted write
  a_no_write_hold: assert property (
    !wr_ack |=> ($stable(wb_fld_q) && $stable(gm_fld_q)))
    else $error("stored field changed without a write");

  a_gm_off_locked: assert property (
    (wr_ack && hit_gm && !gm_on) |=> $stable(gm_fld_q))
    else $error("tone curve written while off");

  a_unmapped_write: assert property (
    (wr_ack && !hit_wb && !hit_gm)
      |=> ($stable(wb_fld_q) && $stable(gm_fld_q)))
    else $error("unmapped write reached a field");

  a_lane_masked: assert property (
    (wr_ack && hit_wb && !avs_byteenable[3])
      |=> $stable(wb_fld_q[31:24]))
    else $error("disabled byte lane written");

  a_blue_low_lane: assert property (
    (wr_ack && hit_wb && wb_on && avs_byteenable[1])
      |=> wb_fld_q[15:8] == $past(avs_writedata[15:8]))
    else $error("blue level low byte not stored");

  a_gm_lane_masked: assert property (
    (wr_ack && hit_gm && !avs_byteenable[2])
      |=> $stable(gm_fld_q[23:20]))
    else $error("tone curve lane written while disabled");

  a_gm_high_lane: assert property (
    (wr_ack && hit_gm && gm_on && avs_byteenable[3])
      |=> gm_fld_q[31:24] == $past(avs_writedata[31:24]))
    else $error("tone curve high byte not stored");

  // applied levels and one-shot outputs
  a_red_source: assert property (
    1'b1 |=> red_level_q == $past(wb_fld_q[31:20]))
    else $error("red level does not follow value field");

  a_push_follows: assert property (
    (!wb_auto && !gm_auto)
      |=> (wb_push_act_q == $past(wb_one_push) && gm_push_act_q == $past(gm_one_push)))
    else $error("one-shot not passed on in manual mode");

  c_wb_write: cover property (wr_ack && hit_wb && wb_on);
  c_gm_read: cover property (st_q == CGFC_ACK && avs_read && hit_gm);
  c_locked_write: cover property (wr_ack && hit_gm && !gm_on);
  c_unmapped: cover property (st_q == CGFC_ACK && !hit_wb && !hit_gm);
  c_auto_push: cover property (gm_auto && gm_one_push);

endmodule

// ==== verilog/cgfc_defs.svh ====
// constants and field layout for the colour balance and tone curve registers
`ifndef CGFC_DEFS_SVH
`define CGFC_DEFS_SVH

`define CGFC_ADDR_W       12
`define CGFC_WB_OFS       12'h80c
`define CGFC_GM_OFS       12'h818

`define CGFC_PRESENT_BIT  0
`define CGFC_ABS_BIT      1
`define CGFC_PUSH_BIT     5
`define CGFC_ON_BIT       6
`define CGFC_AUTO_BIT     7

`define CGFC_PRESENT      1'b1
`define CGFC_ABS_CTL      1'b0

`define CGFC_WB_WMASK     32'hffffff00
`define CGFC_GM_WMASK     32'hfff00000
`define CGFC_WB_RST       32'h00000000
`define CGFC_GM_RST       32'h00000000
`define CGFC_LVL_RST      12'h000
`define CGFC_RD_NONE      32'h00000000

`endif

// ==== verilog/cgfc_pkg.sv ====
// types shared by the colour balance and tone curve register bank
package cgfc_pkg;

  typedef enum logic [1:0] {
    CGFC_IDLE = 2'b01,
    CGFC_ACK  = 2'b10
  } cgfc_state_t;

endpackage
